// File: rtl/pmx_panel_pin_output_mux.sv
`timescale 1ns/10ps
module pmx_panel_pin_output_mux
	import pmx_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [11:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	input wire pmx_src_t src_i,
	input wire logic [31:0] pin_in_en_i,
	input wire logic panel_is_tft_i,
	input wire logic vsync_i,
	input wire logic [31:0] pin_in_i,
	output logic [31:0] pin_out_o,
	output logic [31:0] pin_oe_o,
	output logic [31:0] pulldown_en_o,
	output pmx_codec_in_t codec_in_o,
	output logic crc_enable_o,
	output logic crc_capture_o
);

	// ************************************************************
	// Register file
	// ************************************************************
	logic [31:0] sel_low;
	logic [31:0] sel_high;
	logic [31:0] drive;
	logic [31:0] alt_sel;
	logic [31:0] test_ctrl;
	logic [31:0] input_sample;
	logic [31:0] next_sel_low;
	logic [31:0] next_sel_high;
	logic [31:0] next_drive;
	logic [31:0] next_alt_sel;
	logic [31:0] next_test_ctrl;
	logic [31:0] next_pulldown;

	// Next values feed the pin muxes so a write lands on the pins with no extra stage
	always_comb begin
		next_sel_low = sel_low;
		next_sel_high = sel_high;
		next_drive = drive;
		next_alt_sel = alt_sel;
		next_test_ctrl = test_ctrl;
		next_pulldown = pulldown_en_o;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				PMX_OFF_SEL_LOW: next_sel_low = reg_wdata_i;
				PMX_OFF_SEL_HIGH: next_sel_high = reg_wdata_i;
				PMX_OFF_DRIVE: next_drive = reg_wdata_i;
				PMX_OFF_PULLDOWN: next_pulldown = reg_wdata_i & PMX_PD_MASK;
				PMX_OFF_ALT_SEL: next_alt_sel = reg_wdata_i & PMX_ALT_MASK;
				PMX_OFF_TEST_CTRL: next_test_ctrl = reg_wdata_i & PMX_TEST_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_low <= PMX_RST_WORD;
			sel_high <= PMX_RST_WORD;
			drive <= PMX_RST_WORD;
			alt_sel <= PMX_RST_WORD;
			test_ctrl <= PMX_RST_WORD;
			pulldown_en_o <= PMX_RST_WORD;
		end else begin
			sel_low <= next_sel_low;
			sel_high <= next_sel_high;
			drive <= next_drive;
			alt_sel <= next_alt_sel;
			test_ctrl <= next_test_ctrl;
			pulldown_en_o <= next_pulldown;
		end
	end

	// Reads answer one clock after the strobe; unmapped offsets read zero
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= PMX_RST_WORD;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				PMX_OFF_SEL_LOW: reg_rdata_o <= sel_low;
				PMX_OFF_SEL_HIGH: reg_rdata_o <= sel_high;
				PMX_OFF_DRIVE: reg_rdata_o <= drive;
				PMX_OFF_INPUT: reg_rdata_o <= input_sample;
				PMX_OFF_PULLDOWN: reg_rdata_o <= pulldown_en_o;
				PMX_OFF_ALT_SEL: reg_rdata_o <= alt_sel;
				PMX_OFF_TEST_CTRL: reg_rdata_o <= test_ctrl;
				default: reg_rdata_o <= PMX_RST_WORD;
			endcase
		end
	end

	// ************************************************************
	// Alternate sources
	// ************************************************************
	logic [31:0] alt_val;
	logic [31:0] has_alt;
	logic [31:0] prim_val;
	logic [31:0] spec_val;
	logic [31:0] has_spec;
	logic [31:0] next_pin;

	always_comb begin
		alt_val = PMX_RST_WORD;
		has_alt = PMX_RST_WORD;
		unique case (next_alt_sel[PMX_ALT_LOGIC_PWR +: 2])
			2'h0: alt_val[0] = src_i.ctl_en;
			2'h1: alt_val[0] = src_i.vee_en;
			2'h2: alt_val[0] = src_i.pulse0;
			2'h3: alt_val[0] = src_i.codec_mclk;
		endcase
		unique case (next_alt_sel[PMX_ALT_BIAS_PWR +: 2])
			2'h0: alt_val[1] = src_i.ctl_en;
			2'h1: alt_val[1] = src_i.test_vec[0];
			2'h2: alt_val[1] = src_i.pulse1;
			2'h3: alt_val[1] = src_i.codec_serial_out;
		endcase
		unique case (next_alt_sel[PMX_ALT_MOD +: 2])
			2'h0: alt_val[PMX_PIN_MOD] = src_i.led;
			2'h1: alt_val[PMX_PIN_MOD] = src_i.vdd_en;
			2'h2: alt_val[PMX_PIN_MOD] = src_i.vee_en;
			2'h3: alt_val[PMX_PIN_MOD] = src_i.pulse0;
		endcase
		unique case (next_alt_sel[PMX_ALT_LCLK +: 2])
			2'h0: alt_val[PMX_PIN_LCLK] = src_i.pulse_clk;
			2'h1: alt_val[PMX_PIN_LCLK] = src_i.led;
			2'h2: alt_val[PMX_PIN_LCLK] = src_i.pulse0;
			2'h3: alt_val[PMX_PIN_LCLK] = src_i.codec_bclk;
		endcase
		unique case (next_alt_sel[PMX_ALT_PULSE0 +: 2])
			2'h0: alt_val[PMX_PIN_PULSE0] = src_i.tft[PMX_PIN_MOD];
			2'h1: alt_val[PMX_PIN_PULSE0] = src_i.test_vec[8];
			2'h2: alt_val[PMX_PIN_PULSE0] = src_i.test_vec[9];
			2'h3: alt_val[PMX_PIN_PULSE0] = src_i.codec_frame_sync;
		endcase
		unique case (next_alt_sel[PMX_ALT_PULSE1 +: 2])
			2'h0: alt_val[PMX_PIN_PULSE1] = src_i.alt_lclk;
			2'h1: alt_val[PMX_PIN_PULSE1] = src_i.hsync_free;
			2'h2: alt_val[PMX_PIN_PULSE1] = src_i.vde;
			2'h3: alt_val[PMX_PIN_PULSE1] = src_i.led;
		endcase
		has_alt[0] = 1'b1;
		has_alt[1] = 1'b1;
		has_alt[PMX_PIN_MOD] = 1'b1;
		has_alt[PMX_PIN_LCLK] = 1'b1;
		has_alt[PMX_PIN_PULSE0] = 1'b1;
		has_alt[PMX_PIN_PULSE1] = 1'b1;
	end

	// Primary and code-11 overrides for the pins that differ from the data pins
	always_comb begin
		prim_val = src_i.tft;
		prim_val[PMX_PIN_PULSE0] = src_i.pulse0;
		prim_val[PMX_PIN_PULSE1] = src_i.pulse1;
		spec_val = PMX_RST_WORD;
		has_spec = PMX_RST_WORD;
		spec_val[PMX_PIN_SCLK_DE] = src_i.pulse_clk;
		spec_val[PMX_PIN_PULSE0] = src_i.poly_blank_n;
		spec_val[PMX_PIN_PULSE1] = src_i.mod_ungated;
		has_spec[PMX_PIN_SCLK_DE] = 1'b1;
		has_spec[PMX_PIN_PULSE0] = 1'b1;
		has_spec[PMX_PIN_PULSE1] = 1'b1;
	end

	// ************************************************************
	// Per-pin selector
	// ************************************************************
	for (genvar i = 0; i < 32; i++) begin : g_pin
		logic [1:0] code;
		assign code = {next_sel_low[i], next_sel_high[i]};
		always_comb begin
			unique case (code)
				PMX_SEL_PRIMARY: next_pin[i] = prim_val[i];
				PMX_SEL_DRIVE: next_pin[i] = next_drive[i];
				PMX_SEL_SECOND: next_pin[i] = has_alt[i] ? alt_val[i] : src_i.stn[i];
				PMX_SEL_TEST: next_pin[i] = has_spec[i] ? spec_val[i] : src_i.test[i];
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_out_o <= PMX_RST_WORD;
			pin_oe_o <= PMX_RST_WORD;
		end else begin
			pin_out_o <= next_pin;
			pin_oe_o <= ~pin_in_en_i;
		end
	end

	// ************************************************************
	// Pin input sampling
	// ************************************************************
	logic [31:0] pin_sync1;
	logic [31:0] pin_sync2;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_sync1 <= PMX_RST_WORD;
			pin_sync2 <= PMX_RST_WORD;
			input_sample <= PMX_RST_WORD;
		end else begin
			pin_sync1 <= pin_in_i;
			pin_sync2 <= pin_sync1;
			input_sample <= pin_sync2 & pin_in_en_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			codec_in_o <= '0;
		end else begin
			codec_in_o.root_clk <= pin_sync2[PMX_PIN_MOD];
			codec_in_o.bit_clk <= pin_sync2[PMX_PIN_LCLK];
			codec_in_o.frame_sync <= pin_sync2[PMX_PIN_PULSE0];
			codec_in_o.serial_in <= pin_sync2[PMX_PIN_PULSE1];
		end
	end

	// ************************************************************
	// CRC capture control
	// ************************************************************
	pmx_crc_state_t crc_state;
	pmx_crc_state_t next_crc_state;
	logic [1:0] vs_left;
	logic [1:0] next_vs_left;
	logic crc_on;
	logic [1:0] crc_mode;

	assign crc_on = test_ctrl[PMX_TC_CRC_EN] & panel_is_tft_i;
	assign crc_mode = test_ctrl[PMX_TC_CRC_MODE +: 2];

	always_comb begin
		next_crc_state = crc_state;
		next_vs_left = vs_left;
		if (!crc_on) begin
			next_crc_state = PMX_CRC_IDLE;
		end else begin
			unique case (crc_state)
				PMX_CRC_IDLE: begin
					// Reserved mode stays idle rather than guessing a capture
					if (crc_mode == PMX_CRC_CONT) begin
						next_crc_state = PMX_CRC_RUN;
					end else if (crc_mode != PMX_TEST_MASK[2:1]) begin
						next_crc_state = PMX_CRC_WAIT;
						next_vs_left = (crc_mode == PMX_CRC_WAIT_TWO) ? PMX_VS_TWO : PMX_VS_ONE;
					end
				end
				PMX_CRC_WAIT: begin
					if (vsync_i) begin
						next_vs_left = vs_left - PMX_VS_ONE;
						if (vs_left == PMX_VS_ONE) begin
							next_crc_state = PMX_CRC_CAPT;
						end
					end
				end
				PMX_CRC_CAPT: begin
					if (vsync_i) begin
						next_crc_state = PMX_CRC_DONE;
					end
				end
				PMX_CRC_RUN: ;
				PMX_CRC_DONE: ;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			crc_state <= PMX_CRC_IDLE;
			vs_left <= 2'h0;
			crc_enable_o <= 1'b0;
			crc_capture_o <= 1'b0;
		end else begin
			crc_state <= next_crc_state;
			vs_left <= next_vs_left;
			crc_enable_o <= crc_on;
			crc_capture_o <= (next_crc_state == PMX_CRC_CAPT) ||
				(next_crc_state == PMX_CRC_RUN);
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);

	sequence s_arm_two;
		crc_state == PMX_CRC_IDLE && crc_on && crc_mode == PMX_CRC_WAIT_TWO;
	endsequence
	sequence s_no_capture_yet;
		!crc_capture_o [*2];
	endsequence

	chk_vsync_marker: assert property (
		{sel_low[27], sel_high[27]} == 2'h2 |-> pin_out_o[27] == $past(src_i.stn[27]))
		else $error("vsync pin does not carry first-line marker");
	chk_mod_drive: assert property (
		{sel_low[28], sel_high[28]} == 2'h1 |-> pin_out_o[28] == drive[28])
		else $error("modulation pin does not carry drive value");
	chk_lclk_primary: assert property (
		{sel_low[29], sel_high[29]} == 2'h0 |-> pin_out_o[29] == $past(src_i.tft[29]))
		else $error("line clock pin does not carry line clock");
	chk_pulse0_blank: assert property (
		{sel_low[30], sel_high[30]} == 2'h3 |-> pin_out_o[30] == $past(src_i.poly_blank_n))
		else $error("first pulse pin does not carry blank");
	chk_pulse1_ungated: assert property (
		{sel_low[31], sel_high[31]} == 2'h3 |-> pin_out_o[31] == $past(src_i.mod_ungated))
		else $error("second pulse pin does not carry ungated clock");
	chk_drive_follow: assert property (
		reg_wr_i && reg_addr_i == PMX_OFF_DRIVE && sel_low[5] == 1'b0 && sel_high[5]
		&& !(reg_wr_i && reg_addr_i == PMX_OFF_SEL_LOW) |=> pin_out_o[5] == $past(reg_wdata_i[5]))
		else $error("drive value not on pin one clock after write");
	chk_alt_mclk: assert property (
		{sel_low[0], sel_high[0]} == 2'h2 && alt_sel[1:0] == 2'h3
		|-> pin_out_o[0] == $past(src_i.codec_mclk))
		else $error("logic-power pin does not carry codec master clock");
	chk_crc_tft_only: assert property (
		crc_enable_o |-> $past(panel_is_tft_i) && $past(test_ctrl[0]))
		else $error("crc enabled without tft panel");
	chk_wait_two: assert property (
		s_arm_two |=> s_no_capture_yet)
		else $error("crc captured before two vsyncs");

endmodule : pmx_panel_pin_output_mux

// File: rtl/pmx_pkg.sv
package pmx_pkg;

	// ************************************************************
	// Register offsets (byte addresses in the host register space)
	// ************************************************************
	localparam logic [11:0] PMX_OFF_SEL_LOW = 12'h618;
	localparam logic [11:0] PMX_OFF_SEL_HIGH = 12'h61c;
	localparam logic [11:0] PMX_OFF_DRIVE = 12'h620;
	localparam logic [11:0] PMX_OFF_INPUT = 12'h624;
	localparam logic [11:0] PMX_OFF_PULLDOWN = 12'h628;
	localparam logic [11:0] PMX_OFF_ALT_SEL = 12'h62c;
	localparam logic [11:0] PMX_OFF_TEST_CTRL = 12'h638;

	// ************************************************************
	// Reset values and writable-bit masks
	// ************************************************************
	localparam logic [31:0] PMX_RST_WORD = 32'h0000_0000;
	localparam logic [31:0] PMX_PD_MASK = 32'h0ffc_fcff;
	localparam logic [31:0] PMX_ALT_MASK = 32'h0000_0fff;
	localparam logic [31:0] PMX_TEST_MASK = 32'h0000_0037;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PMX_PIN_VSYNC = 27;
	localparam int PMX_PIN_SCLK_DE = 25;
	localparam int PMX_PIN_MOD = 28;
	localparam int PMX_PIN_LCLK = 29;
	localparam int PMX_PIN_PULSE0 = 30;
	localparam int PMX_PIN_PULSE1 = 31;
	localparam int PMX_ALT_LOGIC_PWR = 0;
	localparam int PMX_ALT_BIAS_PWR = 2;
	localparam int PMX_ALT_MOD = 4;
	localparam int PMX_ALT_LCLK = 6;
	localparam int PMX_ALT_PULSE0 = 8;
	localparam int PMX_ALT_PULSE1 = 10;
	localparam int PMX_TC_CRC_EN = 0;
	localparam int PMX_TC_CRC_MODE = 1;

	// ************************************************************
	// Select codes, written {low bit, high bit}
	// ************************************************************
	localparam logic [1:0] PMX_SEL_PRIMARY = 2'h0;
	localparam logic [1:0] PMX_SEL_DRIVE = 2'h1;
	localparam logic [1:0] PMX_SEL_SECOND = 2'h2;
	localparam logic [1:0] PMX_SEL_TEST = 2'h3;

	localparam logic [1:0] PMX_CRC_WAIT_ONE = 2'h0;
	localparam logic [1:0] PMX_CRC_WAIT_TWO = 2'h1;
	localparam logic [1:0] PMX_CRC_CONT = 2'h2;
	localparam logic [1:0] PMX_VS_ONE = 2'h1;
	localparam logic [1:0] PMX_VS_TWO = 2'h2;

	typedef enum logic [2:0] {
		PMX_CRC_IDLE,
		PMX_CRC_WAIT,
		PMX_CRC_CAPT,
		PMX_CRC_RUN,
		PMX_CRC_DONE
	} pmx_crc_state_t;

	// Signals from the display timing, pulse, codec and test logic
	typedef struct packed {
		logic [31:0] tft;
		logic [31:0] stn;
		logic [31:0] test;
		logic [9:0] test_vec;
		logic pulse_clk;
		logic frame_clk;
		logic poly_blank_n;
		logic mod_ungated;
		logic ctl_en;
		logic vdd_en;
		logic vee_en;
		logic led;
		logic pulse0;
		logic pulse1;
		logic codec_mclk;
		logic codec_serial_out;
		logic codec_bclk;
		logic codec_frame_sync;
		logic alt_lclk;
		logic hsync_free;
		logic vde;
	} pmx_src_t;

	typedef struct packed {
		logic root_clk;
		logic bit_clk;
		logic frame_sync;
		logic serial_in;
	} pmx_codec_in_t;

endpackage : pmx_pkg

// File: test/pmx_panel_model.sv
`timescale 1ns/10ps
// ****
// Panel and codec side of the pins
// ****
module pmx_panel_model
	import pmx_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic [31:0] pin_out_i,
	input wire logic [31:0] pin_oe_i,
	input wire logic [31:0] pulldown_i,
	input wire logic [31:0] far_val_i,
	input wire logic [31:0] far_en_i,
	output logic [31:0] pin_level_o
);
	// A floating pin wanders, so a stale sample never passes by luck
	logic [31:0] drift = 32'h5555_aaaa;
	always @(posedge core_clk_i) begin
		drift <= ~drift;
	end
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (pin_oe_i[i])
				pin_level_o[i] = pin_out_i[i];
			else if (far_en_i[i])
				pin_level_o[i] = far_val_i[i];
			else if (pulldown_i[i])
				pin_level_o[i] = 1'b0;
			else
				pin_level_o[i] = drift[i];
		end
	end
endmodule : pmx_panel_model

// File: test/test_panel_pin_output_mux.sv
`timescale 1ns/10ps
module test_panel_pin_output_mux
	import pmx_pkg::*;
;
	logic core_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [11:0] reg_addr_i = 12'h000;
	logic [31:0] reg_wdata_i = 32'h0;
	logic [31:0] pin_in_en_i = 32'h0;
	logic [31:0] far_val = 32'h0;
	logic [31:0] far_en = 32'h0;
	pmx_src_t src_i = '0;
	logic panel_is_tft_i = 1'b0;
	logic vsync_i = 1'b0;
	logic [31:0] reg_rdata_o, pin_out_o, pin_oe_o, pulldown_en_o, pin_in_i;
	pmx_codec_in_t codec_in_o;
	logic crc_enable_o, crc_capture_o;
	logic [31:0] d, pd;
	int n_errors = 0;
	int checked = 0;
	int cycles = 0;
	localparam logic [11:0] OFFS [6] = '{PMX_OFF_SEL_LOW, PMX_OFF_SEL_HIGH, PMX_OFF_DRIVE,
		PMX_OFF_PULLDOWN, PMX_OFF_ALT_SEL, PMX_OFF_TEST_CTRL};
	localparam logic [31:0] MASKS [6] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
		PMX_PD_MASK, PMX_ALT_MASK, PMX_TEST_MASK};

	always #20 core_clk_i = ~core_clk_i;

	pmx_panel_pin_output_mux i_pmx_panel_pin_output_mux (.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .src_i(src_i),
		.pin_in_en_i(pin_in_en_i), .panel_is_tft_i(panel_is_tft_i), .vsync_i(vsync_i),
		.pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.pulldown_en_o(pulldown_en_o), .codec_in_o(codec_in_o), .crc_enable_o(crc_enable_o),
		.crc_capture_o(crc_capture_o));

	pmx_panel_model i_pmx_panel_model (.core_clk_i(core_clk_i), .pin_out_i(pin_out_o),
		.pin_oe_i(pin_oe_o), .pulldown_i(pulldown_en_o), .far_val_i(far_val),
		.far_en_i(far_en), .pin_level_o(pin_in_i));

	// ****
	// Expectations
	// ****
	function automatic logic [31:0] exp_pins(input logic [31:0] lo, hi, drv, alt,
		input pmx_src_t s);
		logic [31:0] r;
		logic [3:0] v [6];
		int p;
		for (int i = 0; i < 32; i++) begin
			case ({lo[i], hi[i]})
				2'h0: r[i] = s.tft[i];
				2'h1: r[i] = drv[i];
				2'h2: r[i] = s.stn[i];
				default: r[i] = s.test[i];
			endcase
		end
		if ({lo[25], hi[25]} == 2'h3) r[25] = s.pulse_clk;
		if ({lo[30], hi[30]} == 2'h0) r[30] = s.pulse0;
		if ({lo[30], hi[30]} == 2'h3) r[30] = s.poly_blank_n;
		if ({lo[31], hi[31]} == 2'h0) r[31] = s.pulse1;
		if ({lo[31], hi[31]} == 2'h3) r[31] = s.mod_ungated;
		v[0] = {s.codec_mclk, s.pulse0, s.vee_en, s.ctl_en};
		v[1] = {s.codec_serial_out, s.pulse1, s.test_vec[0], s.ctl_en};
		v[2] = {s.pulse0, s.vee_en, s.vdd_en, s.led};
		v[3] = {s.codec_bclk, s.pulse0, s.led, s.pulse_clk};
		v[4] = {s.codec_frame_sync, s.test_vec[9], s.test_vec[8], s.tft[28]};
		v[5] = {s.led, s.vde, s.hsync_free, s.alt_lclk};
		for (int k = 0; k < 6; k++) begin
			p = (k < 2) ? k : k + 26;
			if ({lo[p], hi[p]} == 2'h2) r[p] = v[k][alt[2*k+:2]];
		end
		return r;
	endfunction : exp_pins

	function automatic pmx_src_t rnd_src();
		logic [127:0] t;
		t = {$urandom, $urandom, $urandom, $urandom};
		return pmx_src_t'(t[$bits(pmx_src_t)-1:0]);
	endfunction : rnd_src

	// ****
	// Bus and compare tasks
	// ****
	task automatic close_out();
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask : cyc

	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		reg_addr_i = a;
		reg_wdata_i = v;
		reg_wr_i = 1'b1;
		cyc(1);
		reg_wr_i = 1'b0;
		cyc(1);
	endtask : wr

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp,
		input logic [31:0] m);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		cyc(1);
		reg_rd_i = 1'b0;
		chk(what, exp & m, reg_rdata_o & m);
		cyc(1);
	endtask : rdc

	task automatic mux_check(input logic [31:0] lo, hi, drv, alt);
		wr(PMX_OFF_SEL_LOW, lo);
		wr(PMX_OFF_SEL_HIGH, hi);
		wr(PMX_OFF_DRIVE, drv);
		wr(PMX_OFF_ALT_SEL, alt);
		repeat (2) begin
			src_i = rnd_src();
			pin_in_en_i = $urandom;
			cyc(1);
			chk("pin output", exp_pins(lo, hi, drv, alt, src_i), pin_out_o);
			chk("output enable", ~pin_in_en_i, pin_oe_o);
		end
	endtask : mux_check

	task automatic vs();
		vsync_i = 1'b1;
		cyc(1);
		vsync_i = 1'b0;
		cyc(1);
	endtask : vs

	task automatic crc_run(input logic [1:0] mode, input int n);
		wr(PMX_OFF_TEST_CTRL, 32'h0);
		wr(PMX_OFF_TEST_CTRL, {29'h0, mode, 1'b1});
		cyc(2);
		chk("crc enable", 32'h1, crc_enable_o);
		repeat (n) begin
			chk("capture early", 32'h0, crc_capture_o);
			vs();
			cyc(1);
		end
		chk("capture on", mode != 2'h3, crc_capture_o);
		vs();
		cyc(1);
		chk("capture after", mode == 2'h2, crc_capture_o);
	endtask : crc_run

	// Hang guard, well above the fewer than a thousand cycles the sequence needs
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end

	// ****
	// Main sequence
	// ****
	initial begin
		d = $urandom(75470);
		repeat (6) @(posedge core_clk_i);
		#1;
		arst_n_i = 1'b1;
		cyc(1);
		for (int k = 0; k < 6; k++) begin
			rdc("reset value", OFFS[k], PMX_RST_WORD, 32'hffff_ffff);
			d = $urandom;
			if (k == 3) d = d & PMX_PD_MASK;
			wr(OFFS[k], d);
			rdc("readback", OFFS[k], d & MASKS[k], 32'hffff_ffff);
			if (k == 3) chk("pull-down", d, pulldown_en_o);
		end
		wr(12'h630, $urandom);
		rdc("unmapped", 12'h630, 32'h0, 32'hffff_ffff);
		for (int c = 0; c < 4; c++) begin
			mux_check(32'hffff_ffff, 32'h0, $urandom, 32'(c) * 32'h0000_0555);
		end
		wr(PMX_OFF_SEL_LOW, 32'h0);
		wr(PMX_OFF_SEL_HIGH, 32'hffff_ffff);
		reg_addr_i = PMX_OFF_DRIVE;
		reg_wdata_i = 32'ha5c3_3c5a;
		reg_wr_i = 1'b1;
		cyc(1);
		chk("drive follow", 32'ha5c3_3c5a, pin_out_o);
		reg_wr_i = 1'b0;
		cyc(1);
		repeat (64) begin
			mux_check($urandom, $urandom, $urandom, $urandom & PMX_ALT_MASK);
		end
		repeat (8) begin
			pin_in_en_i = $urandom | 32'hf000_0000;
			far_en = $urandom | 32'hf000_0000;
			far_val = $urandom;
			pd = $urandom & PMX_PD_MASK;
			wr(PMX_OFF_PULLDOWN, pd);
			cyc(4);
			rdc("pin input", PMX_OFF_INPUT, far_val & far_en, pin_in_en_i & (far_en | pd));
			d = {28'h0, far_val[28], far_val[29], far_val[30], far_val[31]};
			chk("codec input", d, 32'(codec_in_o));
		end
		wr(PMX_OFF_TEST_CTRL, 32'h1);
		cyc(2);
		chk("crc enable", 32'h0, crc_enable_o);
		vs();
		cyc(2);
		chk("capture off", 32'h0, crc_capture_o);
		panel_is_tft_i = 1'b1;
		crc_run(PMX_CRC_WAIT_ONE, 1);
		crc_run(PMX_CRC_WAIT_TWO, 2);
		crc_run(PMX_CRC_CONT, 0);
		crc_run(2'h3, 2);
		close_out();
	end
endmodule : test_panel_pin_output_mux
